// ---- hw/vvt_consts.svh ----
`ifndef VVT_CONSTS_SVH
`define VVT_CONSTS_SVH
// register indices behind the data port
`define VVT_IDX_VTOTAL   8'h06
`define VVT_IDX_OVF      8'h07
`define VVT_IDX_PRESET   8'h08
`define VVT_IDX_MAXSCAN  8'h09
`define VVT_IDX_SADDR_HI 8'h0c
`define VVT_IDX_SADDR_LO 8'h0d
`define VVT_IDX_VSS      8'h10
`define VVT_IDX_VSEND    8'h11
`define VVT_IDX_VDE      8'h12
`define VVT_IDX_VBS      8'h15
`define VVT_IDX_LCMP     8'h18
// protected window ends below this index
`define VVT_IDX_PROT_TOP 8'h08
// overflow field positions
`define VVT_OVF_VT8   0
`define VVT_OVF_VDE8  1
`define VVT_OVF_VSS8  2
`define VVT_OVF_VBS8  3
`define VVT_OVF_LC8   4
`define VVT_OVF_VT9   5
`define VVT_OVF_VDE9  6
`define VVT_OVF_VSS9  7
// maximum scan line fields
`define VVT_MSL_VBS9  5
`define VVT_MSL_LC9   6
`define VVT_MSL_DBL   7
// protect bit in sync end register
`define VVT_VSE_PROT  7
// reset values
`define VVT_RST_BYTE  8'h00
`define VVT_RST_MSL   8'h00
`endif

// ---- hw/vvt_pkg.sv ----
package vvt_pkg;
   typedef logic [7:0] vvt_byte_t;
   typedef logic [9:0] vvt_line_t;
   typedef logic [15:0] vvt_addr_t;
endpackage

// ---- hw/vvt_timing.sv ----
`timescale 1ns/1ns
`include "vvt_consts.svh"
`default_nettype none
module vvt_timing (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic io_index_wr,
   input wire logic io_data_wr,
   input wire logic io_data_rd,
   input wire vvt_pkg::vvt_byte_t io_wdata,
   output vvt_pkg::vvt_byte_t io_rdata_r,
   input wire logic line_tick,
   input wire logic nine_dot_mode,
   input wire logic nine_dot_disable,
   input wire vvt_pkg::vvt_byte_t row_offset,
   output vvt_pkg::vvt_line_t scan_line_r,
   output logic vblank_r,
   output logic vsync_r,
   output logic display_active_r,
   output logic split_active_r,
   output logic [4:0] row_scan_r,
   output vvt_pkg::vvt_addr_t mem_addr_r,
   output logic [4:0] pan_pixels_r
);
   import vvt_pkg::*;

   //----------------------------------------------------------
   // register file
   //----------------------------------------------------------
   vvt_byte_t index_r;
   vvt_byte_t vtotal_r, ovf_r, preset_r, maxscan_r;
   vvt_byte_t saddr_hi_r, saddr_lo_r, vss_r, vsend_r;
   vvt_byte_t vde_r, vbs_r, lcmp_r;
   logic wr_ok;
   logic protect;

   assign protect = vsend_r[`VVT_VSE_PROT];
   // protected writes dropped below index 8
   assign wr_ok = io_data_wr &&
      !(protect && index_r < `VVT_IDX_PROT_TOP);

   // index latch
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         index_r <= `VVT_RST_BYTE;
      end else if (io_index_wr) begin
         index_r <= io_wdata;
      end
   end

   // data writes
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         vtotal_r <= `VVT_RST_BYTE;
         preset_r <= `VVT_RST_BYTE;
         maxscan_r <= `VVT_RST_MSL;
         saddr_hi_r <= `VVT_RST_BYTE;
         saddr_lo_r <= `VVT_RST_BYTE;
         vss_r <= `VVT_RST_BYTE;
         vsend_r <= `VVT_RST_BYTE;
         vde_r <= `VVT_RST_BYTE;
         vbs_r <= `VVT_RST_BYTE;
         lcmp_r <= `VVT_RST_BYTE;
      end else if (wr_ok) begin
         case (index_r)
            `VVT_IDX_VTOTAL: vtotal_r <= io_wdata;
            `VVT_IDX_PRESET: preset_r <= {1'b0, io_wdata[6:0]};
            `VVT_IDX_MAXSCAN: maxscan_r <= io_wdata;
            `VVT_IDX_SADDR_HI: saddr_hi_r <= io_wdata;
            `VVT_IDX_SADDR_LO: saddr_lo_r <= io_wdata;
            `VVT_IDX_VSS: vss_r <= io_wdata;
            `VVT_IDX_VSEND: vsend_r <= io_wdata;
            `VVT_IDX_VDE: vde_r <= io_wdata;
            `VVT_IDX_VBS: vbs_r <= io_wdata;
            `VVT_IDX_LCMP: lcmp_r <= io_wdata;
            default: ;
         endcase
      end
   end

   // overflow: bit 4 writable even under protect
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ovf_r <= `VVT_RST_BYTE;
      end else if (io_data_wr && index_r == `VVT_IDX_OVF) begin
         ovf_r[`VVT_OVF_LC8] <= io_wdata[`VVT_OVF_LC8];
         if (!protect) begin
            ovf_r <= io_wdata;
         end
      end
   end

   // read data, unmapped index reads zero
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         io_rdata_r <= `VVT_RST_BYTE;
      end else if (io_data_rd) begin
         case (index_r)
            `VVT_IDX_VTOTAL: io_rdata_r <= vtotal_r;
            `VVT_IDX_OVF: io_rdata_r <= ovf_r;
            `VVT_IDX_PRESET: io_rdata_r <= {1'b0, preset_r[6:0]};
            `VVT_IDX_MAXSCAN: io_rdata_r <= maxscan_r;
            `VVT_IDX_SADDR_HI: io_rdata_r <= saddr_hi_r;
            `VVT_IDX_SADDR_LO: io_rdata_r <= saddr_lo_r;
            `VVT_IDX_VSS: io_rdata_r <= vss_r;
            `VVT_IDX_VSEND: io_rdata_r <= vsend_r;
            `VVT_IDX_VDE: io_rdata_r <= vde_r;
            `VVT_IDX_VBS: io_rdata_r <= vbs_r;
            `VVT_IDX_LCMP: io_rdata_r <= lcmp_r;
            default: io_rdata_r <= `VVT_RST_BYTE;
         endcase
      end
   end

   //----------------------------------------------------------
   // assembled 10-bit values
   //----------------------------------------------------------
   vvt_line_t vbs_w, vss_w, vde_w, vt_w, lc_w;
   assign vbs_w = {maxscan_r[`VVT_MSL_VBS9], ovf_r[`VVT_OVF_VBS8],
      vbs_r};
   assign vss_w = {ovf_r[`VVT_OVF_VSS9], ovf_r[`VVT_OVF_VSS8],
      vss_r};
   assign vde_w = {ovf_r[`VVT_OVF_VDE9], ovf_r[`VVT_OVF_VDE8],
      vde_r};
   assign vt_w = {ovf_r[`VVT_OVF_VT9], ovf_r[`VVT_OVF_VT8],
      vtotal_r};
   assign lc_w = {maxscan_r[`VVT_MSL_LC9], ovf_r[`VVT_OVF_LC8],
      lcmp_r};

   //----------------------------------------------------------
   // vertical line counter
   //----------------------------------------------------------
   logic frame_end;
   vvt_line_t line_nxt;
   // last line is total plus one, frame holds total plus two
   assign frame_end = (scan_line_r == vt_w + 10'h001);
   assign line_nxt = frame_end ? 10'h000 : scan_line_r + 10'h001;

   // line counter advances on each horizontal tick
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         scan_line_r <= 10'h000;
      end else if (line_tick) begin
         scan_line_r <= line_nxt;
      end
   end

   // blanking from start line until the frame wraps
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         vblank_r <= 1'b0;
      end else if (line_tick) begin
         if (line_nxt == vbs_w) begin
            vblank_r <= 1'b1;
         end else if (line_nxt == 10'h000) begin
            vblank_r <= 1'b0;
         end
      end
   end

   // sync from start line until low nibble matches sync end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         vsync_r <= 1'b0;
      end else if (line_tick) begin
         if (line_nxt == vss_w) begin
            vsync_r <= 1'b1;
         end else if (line_nxt[3:0] == vsend_r[3:0]) begin
            vsync_r <= 1'b0;
         end
      end
   end

   // active area is lines zero through display end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         display_active_r <= 1'b0;
      end else if (line_tick) begin
         display_active_r <= (line_nxt <= vde_w);
      end
   end

   //----------------------------------------------------------
   // row scan counter with double scan divider
   //----------------------------------------------------------
   logic half_r;
   logic row_step;
   logic row_done;
   logic split_hit;
   assign row_step = line_tick &&
      (!maxscan_r[`VVT_MSL_DBL] || half_r);
   assign row_done = (row_scan_r == maxscan_r[4:0]);
   assign split_hit = (line_nxt == lc_w) &&
      (line_nxt <= vde_w);

   // divide-by-two phase, restarted each frame
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         half_r <= 1'b0;
      end else if (line_tick) begin
         half_r <= (line_nxt == 10'h000) ? 1'b0 : !half_r;
      end
   end

   // row scan: preset at frame top, zero at split line
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         row_scan_r <= 5'h00;
      end else if (line_tick && line_nxt == 10'h000) begin
         row_scan_r <= preset_r[4:0];
      end else if (line_tick && split_hit) begin
         row_scan_r <= 5'h00;
      end else if (row_step) begin
         row_scan_r <= row_done ? 5'h00 : row_scan_r + 5'h01;
      end
   end

   //----------------------------------------------------------
   // memory address counter and split screen
   //----------------------------------------------------------
   // row start address: start address, zero at split line
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mem_addr_r <= 16'h0000;
      end else if (line_tick && line_nxt == 10'h000) begin
         mem_addr_r <= {saddr_hi_r, saddr_lo_r};
      end else if (line_tick && split_hit) begin
         mem_addr_r <= 16'h0000;
      end else if (row_step && row_done) begin
         mem_addr_r <= mem_addr_r + {8'h00, row_offset};
      end
   end

   // lower part of a split screen is flagged
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         split_active_r <= 1'b0;
      end else if (line_tick) begin
         if (line_nxt == 10'h000) begin
            split_active_r <= 1'b0;
         end else if (split_hit) begin
            split_active_r <= 1'b1;
         end
      end
   end

   //----------------------------------------------------------
   // byte panning
   //----------------------------------------------------------
   logic nine_w;
   logic [4:0] bytes_w;
   assign nine_w = nine_dot_mode && !nine_dot_disable;
   assign bytes_w = {3'b000, preset_r[6:5]};

   // pixel shift is bytes times 9 or 8
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pan_pixels_r <= 5'h00;
      end else begin
         pan_pixels_r <= (bytes_w << 3) +
            (nine_w ? bytes_w : 5'h00);
      end
   end

   //----------------------------------------------------------
   // assertions
   //----------------------------------------------------------
   sequence s_pwr;
      io_data_wr && protect && index_r == `VVT_IDX_VTOTAL;
   endsequence
   sequence s_wrap;
      line_tick && frame_end;
   endsequence

   property p_vblank;
      @(posedge clk) disable iff (!reset_n)
      $rose(vblank_r) |-> scan_line_r == vbs_w;
   endproperty
   a_vblank: assert property (p_vblank)
      else $error("blank began on wrong line");

   property p_vsync;
      @(posedge clk) disable iff (!reset_n)
      $rose(vsync_r) |-> scan_line_r == vss_w;
   endproperty
   a_vsync: assert property (p_vsync)
      else $error("sync began on wrong line");

   property p_wrap;
      @(posedge clk) disable iff (!reset_n)
      s_wrap |=> scan_line_r == 10'h000 && !vblank_r;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("frame did not wrap after total plus one");

   property p_active;
      @(posedge clk) disable iff (!reset_n)
      line_tick && !io_data_wr |=>
         display_active_r == (scan_line_r <= vde_w);
   endproperty
   a_active: assert property (p_active)
      else $error("active flag disagrees with display end");

   property p_split;
      @(posedge clk) disable iff (!reset_n)
      line_tick && split_hit && line_nxt != 10'h000 |=>
         mem_addr_r == 16'h0000 && split_active_r;
   endproperty
   a_split: assert property (p_split)
      else $error("split line did not restart address");

   property p_protect;
      @(posedge clk) disable iff (!reset_n)
      s_pwr |=> $stable(vtotal_r);
   endproperty
   a_protect: assert property (p_protect)
      else $error("protected register was written");

   property p_ovf4;
      @(posedge clk) disable iff (!reset_n)
      io_data_wr && index_r == `VVT_IDX_OVF |=>
         ovf_r[`VVT_OVF_LC8] == $past(io_wdata[`VVT_OVF_LC8]);
   endproperty
   a_ovf4: assert property (p_ovf4)
      else $error("overflow bit 4 not written");

   property p_rsv;
      @(posedge clk) disable iff (!reset_n)
      io_data_rd && index_r == `VVT_IDX_PRESET |=> !io_rdata_r[7];
   endproperty
   a_rsv: assert property (p_rsv)
      else $error("reserved preset bit read as one");

   property p_pan;
      @(posedge clk) disable iff (!reset_n)
      ##1 pan_pixels_r == ($past(preset_r[6:5]) *
         ($past(nine_w) ? 5'd9 : 5'd8));
   endproperty
   a_pan: assert property (p_pan)
      else $error("panning shift wrong");

   property p_dbl;
      @(posedge clk) disable iff (!reset_n)
      line_tick && maxscan_r[`VVT_MSL_DBL] && !half_r &&
         line_nxt != 10'h000 && !split_hit |=> $stable(row_scan_r);
   endproperty
   a_dbl: assert property (p_dbl)
      else $error("row scan advanced on skipped line");

endmodule
`default_nettype wire

// ---- sim/vvt_host.sv ----
`timescale 1ns/1ns
`default_nettype none
// host software model on the indexed register port
module vvt_host (
   input wire logic clk,
   output var logic io_index_wr,
   output var logic io_data_wr,
   output var logic io_data_rd,
   output var vvt_pkg::vvt_byte_t io_wdata,
   input wire vvt_pkg::vvt_byte_t io_rdata_r
);
   import vvt_pkg::*;
   // ------------------------------------------------------------
   // idle port
   // ------------------------------------------------------------
   initial begin
      io_index_wr = 1'b0;
      io_data_wr = 1'b0;
      io_data_rd = 1'b0;
      io_wdata = 8'h00;
   end
   // index write, then data write on the next edge
   task automatic put(input vvt_byte_t idx, input vvt_byte_t val);
      @(posedge clk);
      io_index_wr <= 1'b1;
      io_wdata <= idx;
      @(posedge clk);
      io_index_wr <= 1'b0;
      io_data_wr <= 1'b1;
      io_wdata <= val;
      @(posedge clk);
      io_data_wr <= 1'b0;
      io_wdata <= ~val; // no stale data left on the bus
   endtask
   // index write, read strobe, data settled one cycle later
   task automatic get(input vvt_byte_t idx, output vvt_byte_t val);
      @(posedge clk);
      io_index_wr <= 1'b1;
      io_wdata <= idx;
      @(posedge clk);
      io_index_wr <= 1'b0;
      io_data_rd <= 1'b1;
      io_wdata <= ~idx;
      @(posedge clk);
      io_data_rd <= 1'b0;
      @(negedge clk);
      val = io_rdata_r;
   endtask
endmodule
`default_nettype wire

// ---- sim/tb_vga_vertical_timing_row_scan.sv ----
`timescale 1ns/1ns
`include "vvt_consts.svh"
`default_nettype none
module tb_vga_vertical_timing_row_scan;
   import vvt_pkg::*;
   // ------------------------------------------------------------
   // frame shape
   // ------------------------------------------------------------
   localparam vvt_line_t ACT = 10'h2e1;
   localparam vvt_line_t TOT = 10'h307;
   localparam vvt_line_t VDE = ACT - 10'h001;
   localparam vvt_line_t VT = TOT - 10'h002;
   localparam vvt_line_t VSS = 10'h2f8;
   localparam vvt_line_t VSE = 10'h2fc;
   localparam vvt_line_t VBS = 10'h300;
   localparam vvt_line_t LC = 10'h100;
   localparam vvt_byte_t OVF = {VSS[9], VDE[9], VT[9], LC[8],
                                VBS[8], VSS[8], VDE[8], VT[8]};
   localparam vvt_byte_t MSL = {1'b0, LC[9], VBS[9], 5'h03};
   localparam int LIMIT = 20000;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic line_tick = 1'b0;
   logic nine_dot_mode = 1'b0;
   logic nine_dot_disable = 1'b0;
   vvt_byte_t row_offset = 8'h50;
   logic io_index_wr, io_data_wr, io_data_rd;
   vvt_byte_t io_wdata, io_rdata_r, rd;
   vvt_line_t scan_line_r, el;
   logic vblank_r, vsync_r, display_active_r, split_active_r;
   logic [4:0] row_scan_r, pan_pixels_r;
   vvt_addr_t mem_addr_r;
   vvt_byte_t idx_tab [11];
   vvt_byte_t val_tab [11];
   int bad_count = 0;
   int num_checks = 0;
   int cyc = 0;
   always #50 clk = ~clk;
   vvt_host i_host (.clk(clk), .io_index_wr(io_index_wr),
      .io_data_wr(io_data_wr), .io_data_rd(io_data_rd),
      .io_wdata(io_wdata), .io_rdata_r(io_rdata_r));
   vvt_timing i_dut (.clk(clk), .reset_n(reset_n),
      .io_index_wr(io_index_wr), .io_data_wr(io_data_wr),
      .io_data_rd(io_data_rd), .io_wdata(io_wdata),
      .io_rdata_r(io_rdata_r), .line_tick(line_tick),
      .nine_dot_mode(nine_dot_mode), .nine_dot_disable(nine_dot_disable),
      .row_offset(row_offset), .scan_line_r(scan_line_r),
      .vblank_r(vblank_r), .vsync_r(vsync_r),
      .display_active_r(display_active_r), .split_active_r(split_active_r),
      .row_scan_r(row_scan_r), .mem_addr_r(mem_addr_r),
      .pan_pixels_r(pan_pixels_r));
   // ------------------------------------------------------------
   // compare and report
   // ------------------------------------------------------------
   task automatic end_sim();
      if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk_reg(input vvt_byte_t got, input vvt_byte_t exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         bad_count++;
         end_sim();
      end
   end
   // one line pulse, then the vertical levels of the new line
   task automatic do_line();
      @(posedge clk);
      line_tick <= 1'b1;
      @(posedge clk);
      line_tick <= 1'b0;
      @(negedge clk);
      el = (el == VT + 10'h001) ? 10'h000 : el + 10'h001;
      chk_out(16'(scan_line_r), 16'(el));
      chk_out(16'(vblank_r), 16'(el >= VBS));
      if (el != VSE)
         chk_out(16'(vsync_r), 16'(el >= VSS && el < VSE));
      chk_out(16'(display_active_r), 16'(el <= VDE));
      if (el <= VDE)
         chk_out(16'(split_active_r), 16'(el >= LC));
   endtask
   // counts row scan steps over n lines
   task automatic count_rs(input int n, output int cnt);
      logic [4:0] prev;
      cnt = 0;
      prev = row_scan_r;
      repeat (n) begin
         do_line();
         if (row_scan_r !== prev) cnt++;
         prev = row_scan_r;
      end
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      int n;
      el = 10'h000;
      idx_tab = '{`VVT_IDX_VSEND, `VVT_IDX_VTOTAL, `VVT_IDX_OVF,
         `VVT_IDX_PRESET, `VVT_IDX_MAXSCAN, `VVT_IDX_SADDR_HI,
         `VVT_IDX_SADDR_LO, `VVT_IDX_VSS, `VVT_IDX_VDE, `VVT_IDX_VBS,
         `VVT_IDX_LCMP};
      val_tab = '{8'h0c, VT[7:0], OVF, 8'h01, MSL, 8'h12, 8'h34,
         VSS[7:0], VDE[7:0], VBS[7:0], LC[7:0]};
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      // reset values, then program and read back
      for (int i = 0; i < 11; i++) begin
         i_host.get(idx_tab[i], rd);
         chk_reg(rd, `VVT_RST_BYTE);
      end
      for (int i = 0; i < 11; i++) i_host.put(idx_tab[i], val_tab[i]);
      for (int i = 0; i < 11; i++) begin
         i_host.get(idx_tab[i], rd);
         chk_reg(rd, val_tab[i]);
      end
      // first frame, then row start and row end
      repeat (TOT) do_line();
      chk_out(16'(row_scan_r), 16'h0001);
      chk_out(mem_addr_r, 16'h1234);
      repeat (3) do_line();
      chk_out(16'(row_scan_r), 16'h0000);
      chk_out(mem_addr_r, 16'h1284);
      count_rs(8, n);
      chk_out(16'(n), 16'h0008);
      repeat (LC - 10'd11) do_line();
      chk_out(mem_addr_r, 16'h0000);
      chk_out(16'(row_scan_r), 16'h0000);
      // double scan with a full top row
      i_host.put(`VVT_IDX_MAXSCAN, MSL | 8'h80);
      i_host.put(`VVT_IDX_PRESET, 8'h00);
      repeat (TOT - LC) do_line();
      chk_out(16'(row_scan_r), 16'h0000);
      count_rs(8, n);
      chk_out(16'(n), 16'h0004);
      // byte panning in each character width
      for (int m = 0; m < 3; m++) begin
         for (int c = 0; c < 4; c++) begin
            @(posedge clk);
            nine_dot_mode <= (m < 2);
            nine_dot_disable <= (m == 1);
            i_host.put(`VVT_IDX_PRESET, {1'b0, 2'(c), 5'h00});
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk_out(16'(pan_pixels_r),
               16'(c * (m == 0 ? 9 : 8)));
         end
      end
      i_host.put(`VVT_IDX_PRESET, 8'hff);
      i_host.get(`VVT_IDX_PRESET, rd);
      chk_reg(rd, 8'h7f);
      // write protect keeps only the line compare overflow bit open below index 8
      i_host.put(`VVT_IDX_VSEND, 8'h8c);
      i_host.put(`VVT_IDX_VTOTAL, 8'h55);
      i_host.get(`VVT_IDX_VTOTAL, rd);
      chk_reg(rd, VT[7:0]);
      i_host.put(`VVT_IDX_OVF, 8'h00);
      i_host.get(`VVT_IDX_OVF, rd);
      chk_reg(rd, OVF & 8'hef);
      i_host.put(`VVT_IDX_VSEND, 8'h0c);
      i_host.put(`VVT_IDX_VTOTAL, 8'h55);
      i_host.get(`VVT_IDX_VTOTAL, rd);
      chk_reg(rd, 8'h55);
      // unmapped index
      i_host.put(8'h3f, 8'haa);
      i_host.get(8'h3f, rd);
      chk_reg(rd, 8'h00);
      end_sim();
   end
endmodule
`default_nettype wire
